// ==== core/tmo_cfg.svh ====
// Constants of the three-channel timer: offsets, field positions, codes.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef TMO_CFG_SVH
`define TMO_CFG_SVH

// ========================================================================
// Register offsets (printed byte addresses on the 16-bit port)
`define TMO_OFS_VECTOR     16'h012e
`define TMO_OFS_CONTROL    16'h0160
`define TMO_OFS_CH0_CTL    16'h0162
`define TMO_OFS_CH1_CTL    16'h0164
`define TMO_OFS_CH2_CTL    16'h0166
`define TMO_OFS_COUNT      16'h0170
`define TMO_OFS_CH0_VAL    16'h0172
`define TMO_OFS_CH1_VAL    16'h0174
`define TMO_OFS_CH2_VAL    16'h0176

// ========================================================================
// Timer control fields
`define TMO_CTL_DIV_HI     7
`define TMO_CTL_DIV_LO     6
`define TMO_CTL_MODE_HI    5
`define TMO_CTL_MODE_LO    4
`define TMO_CTL_CLR        2
`define TMO_CTL_ROLL_IE    1
`define TMO_CTL_ROLL_FLG   0

// ========================================================================
// Channel control fields
`define TMO_CH_CAP         8
`define TMO_CH_OM_HI       7
`define TMO_CH_OM_LO       5
`define TMO_CH_IE          4
`define TMO_CH_CCI         3
`define TMO_CH_OUT         2
`define TMO_CH_COV         1
`define TMO_CH_FLG         0

// ========================================================================
// Vector codes and counter constants
`define TMO_VEC_NONE       16'h0000
`define TMO_VEC_CH1        16'h0002
`define TMO_VEC_CH2        16'h0004
`define TMO_VEC_ROLL       16'h000a
`define TMO_CNT_MAX        16'hffff
`define TMO_RST_WORD       16'h0000

`endif

// ==== core/tmo_pkg.sv ====
// Types shared by the three-channel timer.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
`include "tmo_cfg.svh"

package tmo_pkg;

    // ====================================================================
    // Counting modes, as coded in the control word
    typedef enum logic [1:0] {
        TMO_STOP = 2'h0,
        TMO_UP   = 2'h1,
        TMO_CONT = 2'h2,
        TMO_UPDN = 2'h3
    } tmo_count_mode_t;

    // ====================================================================
    // Output modes of each channel output unit
    typedef enum logic [2:0] {
        TMO_OM_OUT     = 3'h0,
        TMO_OM_SET     = 3'h1,
        TMO_OM_TGL_RST = 3'h2,
        TMO_OM_SET_RST = 3'h3,
        TMO_OM_TGL     = 3'h4,
        TMO_OM_RST     = 3'h5,
        TMO_OM_TGL_SET = 3'h6,
        TMO_OM_RST_SET = 3'h7
    } tmo_out_mode_t;

    // ====================================================================
    // Direction state of up/down counting, one-hot
    typedef enum logic [1:0] {
        TMO_DIR_UP   = 2'b01,
        TMO_DIR_DOWN = 2'b10
    } tmo_dir_t;

endpackage

`default_nettype wire

// ==== core/tmo_timer.sv ====
// 16-bit timer, three capture/compare channels, outputs and interrupts.
// Assumes a processor on the plain register port, synchronous inputs,
// and one 125 MHz clock driving every flip-flop.
`timescale 1ns/1ps
`default_nettype none
`include "tmo_cfg.svh"

// Operation
// - Up mode: outputs act on match, rollover
// - Continuous mode: outputs act on both matches
// - Up/down: outputs act on matches, both directions
// - Two requests: period, and shared
// - Capture sets channel event flag
// - Compare match sets channel event flag
// - Software sets and clears event flags
// - Request needs channel and global enable
// - Period flag owns dedicated request line
// - Period flag clears on acknowledge
// - Ch1, ch2, rollover merge with vector
// - Vector shows highest enabled pending source
// - Vector access clears reported flag
// - Shared request stays while others pend
// - Vector codes 0, 2, 4, 10
// - Outputs clocked except mode 0
// - Output mode decode table
// - Compare match drives output unit
module tmo_timer
    import tmo_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  capture_in,
    input  wire logic        global_irq_enable,
    input  wire logic        period_irq_ack,
    output logic             period_irq,
    output logic             shared_irq,
    output logic      [2:0]  channel_output
);

    // ====================================================================
    // State
    logic [1:0]      div_sel_q;      // Input divider select
    tmo_count_mode_t cmode_q;        // Counting mode
    logic            roll_ie_q;      // Rollover interrupt enable
    logic            rollover_flag_q;
    logic [15:0]     count_value_q;  // Running count
    logic [15:0]     count_d;
    tmo_dir_t        dir_q;          // Latched up/down direction
    tmo_dir_t        dir_d;
    logic [2:0]      div_cnt_q;      // Prescaler
    logic [15:0]     ccr_q [3];      // Compare/capture values
    logic [2:0]      cap_q;          // Capture mode select
    tmo_out_mode_t   omode_q [3];    // output_mode_field per channel
    logic [2:0]      ch_ie_q;        // channel_irq_enable
    logic [2:0]      out_bit_q;      // Software output bit
    logic [2:0]      cov_q;          // Capture overflow
    logic [2:0]      flag_q;         // channel_event_flag
    logic [2:0]      out_q;          // Clocked output state
    logic [2:0]      cap_in_q;       // Previous capture input level
    logic [15:0]     vec_d;          // Current vector code

    // ====================================================================
    // Decode of bus strobes
    logic wr_ctl, wr_cnt, vec_acc, clr_req;
    logic [2:0] wr_chc, wr_chv;
    assign wr_ctl  = reg_wr && (reg_addr == `TMO_OFS_CONTROL);
    assign wr_cnt  = reg_wr && (reg_addr == `TMO_OFS_COUNT);
    assign wr_chc  = {reg_wr && (reg_addr == `TMO_OFS_CH2_CTL),
                      reg_wr && (reg_addr == `TMO_OFS_CH1_CTL),
                      reg_wr && (reg_addr == `TMO_OFS_CH0_CTL)};
    assign wr_chv  = {reg_wr && (reg_addr == `TMO_OFS_CH2_VAL),
                      reg_wr && (reg_addr == `TMO_OFS_CH1_VAL),
                      reg_wr && (reg_addr == `TMO_OFS_CH0_VAL)};
    // Read or write of the vector both count as an access
    assign vec_acc = (reg_wr || reg_rd) && (reg_addr == `TMO_OFS_VECTOR);
    // Clear bit is a pulse; it never stays stored
    assign clr_req = wr_ctl && reg_wdata[`TMO_CTL_CLR];

    // ====================================================================
    // Divider: one-cycle tick at the selected rate
    logic [2:0] div_mask;
    logic       tick;
    assign div_mask = (3'h1 << div_sel_q) - 3'h1;
    assign tick     = ((div_cnt_q & div_mask) == div_mask);
    // Prescaler; the clear pulse restarts it together with the count
    always_ff @(posedge clk) begin
        div_cnt_q <= (sys_rst || clr_req) ? 3'h0 : div_cnt_q + 3'h1;
    end

    // ====================================================================
    // Next count and direction per counting mode
    logic adv, roll_evt;
    assign adv = tick && (cmode_q != TMO_STOP);
    always_comb begin
        count_d  = count_value_q;
        dir_d    = dir_q;
        roll_evt = 1'b0;
        case (cmode_q)
            TMO_UP: begin
                // Wrap after sitting on the period value
                roll_evt = (count_value_q >= ccr_q[0]);
                count_d  = roll_evt ? 16'h0000 : count_value_q + 16'h0001;
            end
            TMO_CONT: begin
                count_d  = count_value_q + 16'h0001;
                roll_evt = (count_value_q == `TMO_CNT_MAX);
            end
            TMO_UPDN: begin
                case (dir_q)
                    TMO_DIR_UP: begin
                        if (count_value_q >= ccr_q[0]) begin
                            count_d = count_value_q - 16'h0001;
                            dir_d   = TMO_DIR_DOWN;
                        end else begin
                            count_d = count_value_q + 16'h0001;
                        end
                    end
                    TMO_DIR_DOWN: begin
                        count_d = count_value_q - 16'h0001;
                        // Flag on the step from 1 down to 0
                        if (count_value_q <= 16'h0001) begin
                            count_d  = 16'h0000;
                            dir_d    = TMO_DIR_UP;
                            roll_evt = (count_value_q == 16'h0001);
                        end
                    end
                    default: dir_d = TMO_DIR_UP;
                endcase
            end
            default: count_d = count_value_q;
        endcase
    end
    // Counter and direction registers
    always_ff @(posedge clk) begin
        if (sys_rst || clr_req) begin
            count_value_q <= `TMO_RST_WORD;
            dir_q         <= TMO_DIR_UP;
        end else if (wr_cnt) begin
            count_value_q <= reg_wdata;
        end else if (adv) begin
            count_value_q <= count_d;
            dir_q         <= dir_d;
        end
    end

    // ====================================================================
    // Matches and the period event
    logic [2:0] channel_match;
    logic       period_evt;
    always_comb begin
        for (int i = 0; i < 3; i++) channel_match[i] = adv && (count_d == ccr_q[i]);
    end
    // other modes act on period match
    assign period_evt = (cmode_q == TMO_UP) ? (adv && roll_evt)
                                            : channel_match[0];

    // ====================================================================
    // Control register fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_sel_q <= 2'h0;
            cmode_q   <= TMO_STOP;
            roll_ie_q <= 1'b0;
        end else if (wr_ctl) begin
            div_sel_q <= reg_wdata[`TMO_CTL_DIV_HI:`TMO_CTL_DIV_LO];
            cmode_q   <= tmo_count_mode_t'(
                         reg_wdata[`TMO_CTL_MODE_HI:`TMO_CTL_MODE_LO]);
            roll_ie_q <= reg_wdata[`TMO_CTL_ROLL_IE];
        end
    end

    // ====================================================================
    // Vector: priority encode of enabled pending sources
    logic [2:0] pend;  // ch1, ch2, rollover with enables applied
    assign pend = {roll_ie_q && rollover_flag_q,
                   ch_ie_q[2] && flag_q[2],
                   ch_ie_q[1] && flag_q[1]};
    always_comb begin
        if (pend[0]) begin
            vec_d = `TMO_VEC_CH1;
        end else if (pend[1]) begin
            vec_d = `TMO_VEC_CH2;
        end else if (pend[2]) begin
            vec_d = `TMO_VEC_ROLL;
        end else begin
            vec_d = `TMO_VEC_NONE;
        end
    end
    logic [2:0] vec_clr;
    assign vec_clr = {vec_acc && (vec_d == `TMO_VEC_ROLL),
                      vec_acc && (vec_d == `TMO_VEC_CH2),
                      vec_acc && (vec_d == `TMO_VEC_CH1)};
    // Rollover flag: hardware set wins over any clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rollover_flag_q <= 1'b0;
        end else if (adv && roll_evt) begin
            rollover_flag_q <= 1'b1;
        end else if (wr_ctl) begin
            rollover_flag_q <= reg_wdata[`TMO_CTL_ROLL_FLG];
        end else if (vec_clr[2]) begin
            rollover_flag_q <= 1'b0;
        end
    end

    // ====================================================================
    // Per-channel logic
    logic [2:0] cap_evt, hw_set, flag_clr;
    // Capture on rising edge of the selected input
    assign cap_evt  = cap_q & capture_in & ~cap_in_q;
    assign hw_set   = (cap_q & cap_evt) | (~cap_q & channel_match);
    assign flag_clr = {vec_clr[1], vec_clr[0],
                       period_irq_ack && period_irq};
    // Edge detector history of capture inputs
    always_ff @(posedge clk) begin
        cap_in_q <= sys_rst ? 3'h0 : capture_in;
    end
    for (genvar i = 0; i < 3; i++) begin : g_chan
        // Control fields of the channel
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                cap_q[i]     <= 1'b0;
                omode_q[i]   <= TMO_OM_OUT;
                ch_ie_q[i]   <= 1'b0;
                out_bit_q[i] <= 1'b0;
            end else if (wr_chc[i]) begin
                // software walks modes via mode 7
                cap_q[i]     <= reg_wdata[`TMO_CH_CAP];
                omode_q[i]   <= tmo_out_mode_t'(
                                reg_wdata[`TMO_CH_OM_HI:`TMO_CH_OM_LO]);
                ch_ie_q[i]   <= reg_wdata[`TMO_CH_IE];
                out_bit_q[i] <= reg_wdata[`TMO_CH_OUT];
            end
        end
        // Event flag; hardware set beats software and vector clear
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                flag_q[i] <= 1'b0;
            end else if (hw_set[i]) begin
                flag_q[i] <= 1'b1;
            end else if (wr_chc[i]) begin
                flag_q[i] <= reg_wdata[`TMO_CH_FLG];
            end else if (flag_clr[i]) begin
                flag_q[i] <= 1'b0;
            end
        end
        // Overflow: capture while previous one unread
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                cov_q[i] <= 1'b0;
            end else if (cap_evt[i] && flag_q[i]) begin
                cov_q[i] <= 1'b1;
            end else if (wr_chc[i] && !reg_wdata[`TMO_CH_COV]) begin
                cov_q[i] <= 1'b0;
            end
        end
        // Value register; a capture beats a software write
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                ccr_q[i] <= `TMO_RST_WORD;
            end else if (cap_evt[i]) begin
                ccr_q[i] <= count_value_q;
            end else if (wr_chv[i]) begin
                ccr_q[i] <= reg_wdata;
            end
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                out_q[i] <= 1'b0;
            end else begin
                case (omode_q[i])
                    TMO_OM_OUT: out_q[i] <= out_bit_q[i];
                    TMO_OM_SET: if (channel_match[i]) out_q[i] <= 1'b1;
                    TMO_OM_TGL_RST: begin
                        if (period_evt) out_q[i] <= 1'b0;
                        else if (channel_match[i]) out_q[i] <= ~out_q[i];
                    end
                    TMO_OM_SET_RST: begin
                        if (period_evt) out_q[i] <= 1'b0;
                        else if (channel_match[i]) out_q[i] <= 1'b1;
                    end
                    TMO_OM_TGL: if (channel_match[i]) out_q[i] <= ~out_q[i];
                    TMO_OM_RST: if (channel_match[i]) out_q[i] <= 1'b0;
                    TMO_OM_TGL_SET: begin
                        if (period_evt) out_q[i] <= 1'b1;
                        else if (channel_match[i]) out_q[i] <= ~out_q[i];
                    end
                    TMO_OM_RST_SET: begin
                        if (period_evt) out_q[i] <= 1'b1;
                        else if (channel_match[i]) out_q[i] <= 1'b0;
                    end
                    default: out_q[i] <= out_q[i];
                endcase
            end
        end
        // mode 0 passes output bit at once
        // Mode 0 is a plain decode, so a pass through it can glitch
        assign channel_output[i] = (omode_q[i] == TMO_OM_OUT) ?
                                   out_bit_q[i] : out_q[i];
    end

    // ====================================================================
    // Interrupt requests
    // two request lines
    // period flag on its own line
    assign period_irq = flag_q[0] && ch_ie_q[0] && global_irq_enable;
    // merged request for ch1, ch2, rollover
    assign shared_irq = (|pend) && global_irq_enable;

    // ====================================================================
    // Read data, one cycle after the strobe; unmapped reads zero
    logic [15:0] rd_d;
    always_comb begin
        rd_d = 16'h0000;
        case (reg_addr)
            `TMO_OFS_VECTOR:  rd_d = vec_d;
            `TMO_OFS_CONTROL: rd_d = {8'h00, div_sel_q, cmode_q, 1'b0,
                                      1'b0, roll_ie_q, rollover_flag_q};
            `TMO_OFS_CH0_CTL,
            `TMO_OFS_CH1_CTL,
            `TMO_OFS_CH2_CTL: begin
                for (int i = 0; i < 3; i++) begin
                    if (reg_addr[2:1] == 2'(i + 1))
                        rd_d = {7'h00, cap_q[i], omode_q[i], ch_ie_q[i], capture_in[i],
                                out_bit_q[i], cov_q[i], flag_q[i]};
                end
            end
            `TMO_OFS_COUNT:   rd_d = count_value_q;
            `TMO_OFS_CH0_VAL: rd_d = ccr_q[0];
            `TMO_OFS_CH1_VAL: rd_d = ccr_q[1];
            `TMO_OFS_CH2_VAL: rd_d = ccr_q[2];
            default:          rd_d = 16'h0000;
        endcase
    end
    // Read data register; stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        reg_rdata <= (sys_rst || !reg_rd) ? 16'h0000 : rd_d;
    end
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
// Testbench: register-level scenarios for the three-channel timer.
// Assumes the design, checker and processor model compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tmo_cfg.svh"
module testbench
    import tmo_pkg::*;
();
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [2:0]  capture_in = 3'h0;
    logic        global_irq_enable = 1'b0;
    logic        ack_en = 1'b0;
    logic        period_irq_ack, period_irq, shared_irq;
    logic [15:0] reg_rdata, rd_v;
    logic [2:0]  channel_output;
    int          err_total = 0, samples_checked = 0, hi;
    // ======================================================
    // Clock, design, processor model
    always #4 clk = ~clk;
    tmo_timer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capture_in(capture_in), .global_irq_enable(global_irq_enable),
        .period_irq_ack(period_irq_ack), .period_irq(period_irq),
        .shared_irq(shared_irq), .channel_output(channel_output));
    tmo_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en), .ack_lat(2'h2),
        .period_irq(period_irq), .period_irq_ack(period_irq_ack));
    // ======================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write, settled after
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data land one cycle later
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // High cycles of channel 1 output
    task automatic msr(input int n);
        hi = 0;
        repeat (n) begin
            @(negedge clk);
            hi += int'(channel_output[1]);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ======================================================
    // Scenarios
    task automatic t_reset();
        chk({13'h0, channel_output}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd(`TMO_OFS_CONTROL + 16'(2 * i));
            chk(rd_v, `TMO_RST_WORD);
            rd(`TMO_OFS_COUNT + 16'(2 * i));
            chk(rd_v, `TMO_RST_WORD);
        end
        // Unmapped place stores nothing
        wr(16'h0200, 16'hffff);
        rd(16'h0200);
        chk(rd_v, 16'h0000);
    endtask
    task automatic t_period();
        wr(`TMO_OFS_CH0_CTL, 16'h0011);
        chk({15'h0, period_irq}, 16'h0000);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        #1 chk({15'h0, period_irq}, 16'h0001);
        wr(`TMO_OFS_CH0_CTL, 16'h0010);
        chk({15'h0, period_irq}, 16'h0000);
        wr(`TMO_OFS_CH0_CTL, 16'h0011);
        ack_en <= 1'b1;
        // Bounded wait for service
        for (int n = 0; n < 8 && period_irq !== 1'b0; n++)
            @(posedge clk) #1;
        ack_en <= 1'b0;
        if (period_irq !== 1'b0) begin
            err_total++;
            summarize();
        end
        rd(`TMO_OFS_CH0_CTL);
        chk(rd_v, 16'h0010);
    endtask
    task automatic t_vector();
        logic [15:0] exp [4] = '{`TMO_VEC_CH1, `TMO_VEC_CH2, `TMO_VEC_ROLL, `TMO_VEC_NONE};
        wr(`TMO_OFS_CH1_CTL, 16'h0011);
        wr(`TMO_OFS_CH2_CTL, 16'h0011);
        wr(`TMO_OFS_CONTROL, 16'h0003);
        chk({15'h0, shared_irq}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            rd(`TMO_OFS_VECTOR);
            chk(rd_v, exp[i]);
            chk({15'h0, shared_irq}, {15'h0, i < 2});
        end
        // Disabled source stays out of the vector
        wr(`TMO_OFS_CH2_CTL, 16'h0001);
        wr(`TMO_OFS_CH1_CTL, 16'h0011);
        rd(`TMO_OFS_VECTOR);
        chk(rd_v, `TMO_VEC_CH1);
        rd(`TMO_OFS_VECTOR);
        chk(rd_v, `TMO_VEC_NONE);
        rd(`TMO_OFS_CH2_CTL);
        chk(rd_v, 16'h0001);
        // Write access also clears
        wr(`TMO_OFS_CH1_CTL, 16'h0011);
        wr(`TMO_OFS_VECTOR, 16'h0000);
        rd(`TMO_OFS_CH1_CTL);
        chk(rd_v, 16'h0010);
    endtask
    task automatic t_capture();
        wr(`TMO_OFS_CH2_CTL, 16'h0100);
        wr(`TMO_OFS_COUNT, 16'h1234);
        @(posedge clk) capture_in <= 3'h4;
        @(posedge clk) capture_in <= 3'h0;
        rd(`TMO_OFS_CH2_VAL);
        chk(rd_v, 16'h1234);
        rd(`TMO_OFS_CH2_CTL);
        chk(rd_v, 16'h0101);
    endtask
    task automatic t_outputs();
        wr(`TMO_OFS_CH0_VAL, 16'h0004);
        wr(`TMO_OFS_CH1_VAL, 16'h0002);
        wr(`TMO_OFS_CH1_CTL, 16'h0004);
        chk({13'h0, channel_output}, 16'h0002);
        wr(`TMO_OFS_CH1_CTL, 16'h0000);
        chk({13'h0, channel_output}, 16'h0000);
        wr(`TMO_OFS_CH1_CTL, 16'h0060);
        wr(`TMO_OFS_CONTROL, 16'h0024);
        msr(20);
        chk(16'(hi), 16'd2);
        wr(`TMO_OFS_CONTROL, 16'h0014);
        repeat (10) @(posedge clk);
        msr(20);
        chk(16'(hi), 16'd12);
        rd(`TMO_OFS_CH1_CTL);
        chk(rd_v & 16'h0001, 16'h0001);
        rd(`TMO_OFS_CONTROL);
        chk(rd_v & 16'h0001, 16'h0001);
        wr(`TMO_OFS_CONTROL, 16'h0034);
        repeat (10) @(posedge clk);
        msr(24);
        chk(16'(hi), 16'd18);
        // pass mode 7 on the way to reset mode
        wr(`TMO_OFS_CH1_CTL, 16'h00e0);
        wr(`TMO_OFS_CH1_CTL, 16'h00a0);
        repeat (10) @(posedge clk);
        msr(10);
        chk(16'(hi), 16'd0);
    endtask
    // ======================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_period();
        t_vector();
        t_capture();
        t_outputs();
        summarize();
    end
    initial begin
        #100000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire

// ==== sim/tmo_cpu_model.sv ====
// Processor side model: services the dedicated period request.
// Assumes the timer clock and reset; acks after a chosen latency.
`timescale 1ns/1ps
`default_nettype none
module tmo_cpu_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ack_en,
    input  wire logic [1:0] ack_lat,
    input  wire logic       period_irq,
    output logic            period_irq_ack
);
    // Cycles the request has waited
    logic [1:0] wait_q;
    // ======================================================
    // Service handshake
    // serve dedicated line, one pulse
    always_ff @(posedge clk) begin
        // Idle unless request pending and enabled
        if (sys_rst || !period_irq || !ack_en || period_irq_ack) begin
            wait_q         <= 2'h0;
            period_irq_ack <= 1'b0;
        end else begin
            wait_q         <= wait_q + 2'h1;
            period_irq_ack <= (wait_q == ack_lat);
        end
    end
endmodule
`default_nettype wire

// ==== sim/tmo_timer_chk.sv ====
// Checker: bus timing, vector codes and request gating of the timer.
// Assumes binding onto tmo_timer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "tmo_cfg.svh"
module tmo_timer_chk
    import tmo_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0]  capture_in,
    input wire logic        global_irq_enable,
    input wire logic        period_irq_ack,
    input wire logic        period_irq,
    input wire logic        shared_irq,
    input wire logic [2:0]  channel_output
);
    // ======================================================
    // Clocking and vector access
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Vector read cycle
    sequence s_vec_rd;
        reg_rd && reg_addr == `TMO_OFS_VECTOR;
    endsequence
    // ======================================================
    // Properties
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (reg_rd && reg_addr[15:9] != 7'h00 |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_vec_codes: assert property (s_vec_rd |=> reg_rdata inside
        {`TMO_VEC_NONE, `TMO_VEC_CH1, `TMO_VEC_CH2, `TMO_VEC_ROLL}) else $error("bad code");
    a_vec_reports: assert property (shared_irq ##0 s_vec_rd |=>
        reg_rdata != 16'h0000) else $error("pending source not reported");
    a_vec_empty: assert property (global_irq_enable && !shared_irq ##0 s_vec_rd |=>
        reg_rdata == 16'h0000) else $error("vector without enabled source");
    a_period_gate: assert property (period_irq |-> global_irq_enable)
        else $error("period request without global enable");
    a_shared_gate: assert property (!global_irq_enable |-> !shared_irq)
        else $error("shared request without global enable");
    a_ack_clears: assert property (period_irq && period_irq_ack |=> !period_irq)
        else $error("period flag kept after ack");
endmodule
bind tmo_timer tmo_timer_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_in(capture_in), .global_irq_enable(global_irq_enable),
    .period_irq_ack(period_irq_ack), .period_irq(period_irq), .shared_irq(shared_irq),
    .channel_output(channel_output));
`default_nettype wire
